// ===== mpfc_top.sv
// modem pin function configuration: APB register file and pin drive logic
// Behaviour
// - bit 7 turns on the pull-up only while the pin is an input.
// - bit 6 turns on the pull-down only for an input without pull-up.
// - carrier detect field: 00 input, 01 open drain, 10 push-pull.
// - ring/wake field: 00 input, 01 open drain, 10 push-pull.
// - terminal ready field adds 011 open-drain and 100 push-pull modem.
// - set ready field: 00 input, 01 open drain, 10 push-pull.
//
// The APB register port was decided locally.
`timescale 1ns/1ps

module mpfc_top #(
  parameter int ADDR_W = 12
) (
  input  wire logic                  pclk,
  input  wire logic                  presetn,
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [ADDR_W-1:0]     paddr,
  input  wire logic [31:0]           pwdata,
  output logic                       pready,
  output logic [31:0]                prdata,
  output logic                       pslverr,
  input  wire mpfc_pkg::mpfc_cfg_arr_t otp_cfg,
  input  wire logic                  modem_terminal_ready,
  input  wire logic [3:0]            pin_in,
  output logic [3:0]                 pin_o,
  output logic [3:0]                 pin_oe_n,
  output logic [3:0]                 pull_up_en,
  output logic [3:0]                 pull_down_en
);

  // =====================================================================
  // elaboration check
  // decode reads bits 9:2 and checks that every bit above them is zero
  if (ADDR_W < 11)
  begin : g_bad_addr
    $error("mpfc_top: ADDR_W must be at least 11");
  end

  // =====================================================================
  // state
  mpfc_pkg::mpfc_state_t s;
  mpfc_pkg::mpfc_state_t next_s;

  logic       setup_ph;
  logic       wr_acc;
  logic [7:0] idx;
  logic       aligned;

  // bus phase decode
  assign setup_ph = psel && !penable;
  assign wr_acc   = psel && penable && pwrite;
  assign idx      = paddr[9:2];
  assign aligned  = (paddr[1:0] == 2'b00) && (paddr[ADDR_W-1:10] == '0);

  // field mask per slot; reserved bits are dropped and read back as zero
  function automatic logic [7:0] slot_mask(input int slot);
    slot_mask = (slot == mpfc_pkg::SLOT_DTR) ? mpfc_pkg::MASK_FUNC3
                                             : mpfc_pkg::MASK_FUNC2;
  endfunction

  // =====================================================================
  // next state
  always_comb
  begin
    logic [2:0] fn;
    logic       hit;
    logic       drv;
    int         slot;
    fn     = mpfc_pkg::FN_IN;
    drv    = 1'b0;
    hit    = 1'b0;
    slot   = 0;
    next_s = s;

    // two-flop synchroniser on the pad inputs
    next_s.sync1  = pin_in;
    next_s.sync2  = s.sync1;
    next_s.pready = 1'b1;   // zero wait states

    // one-shot OTP load in the first cycle after reset
    if (!s.loaded)
    begin
      next_s.loaded = 1'b1;
      for (int i = 0; i < mpfc_pkg::NUM_PINS; i++)
      begin
        next_s.cfg[i] = otp_cfg[i] & slot_mask(i);
      end
    end

    // address decode for the settings block
    if (idx >= mpfc_pkg::IDX_CD_CFG && idx <= mpfc_pkg::IDX_DSR_CFG)
    begin
      hit  = 1'b1;
      slot = int'(idx - mpfc_pkg::IDX_CD_CFG);
    end

    // read data and error answer are prepared in the setup cycle
    if (setup_ph)
    begin
      next_s.prdata  = 32'h0000_0000;
      next_s.pslverr = 1'b0;
      if (aligned && hit)
        next_s.prdata = {24'h00_0000, s.cfg[slot]};
      else if (aligned && idx == mpfc_pkg::IDX_OUT_VAL)
        next_s.prdata = {28'h000_0000, s.out_val};
      else if (aligned && idx == mpfc_pkg::IDX_IN_LVL && !pwrite)
        next_s.prdata = {28'h000_0000, s.sync2};
      else
        next_s.pslverr = 1'b1;
    end

    // writes land at the access edge; a bus write beats the OTP load
    if (wr_acc && aligned && hit)
      next_s.cfg[slot] = pwdata[7:0] & slot_mask(slot);
    else if (wr_acc && aligned && idx == mpfc_pkg::IDX_OUT_VAL)
      next_s.out_val = pwdata[3:0];

    // pin drive follows the new settings at the same edge as the write
    for (int i = 0; i < mpfc_pkg::NUM_PINS; i++)
    begin
      if (i == mpfc_pkg::SLOT_DTR)
        fn = next_s.cfg[i][2:0];
      // code 11 on a two-bit pin must not reach the modem branches
      else if (next_s.cfg[i][1:0] == 2'b11)
        fn = 3'h7;
      else
        fn = {1'b0, next_s.cfg[i][1:0]};
      next_s.pins.o[i]    = 1'b1;
      next_s.pins.oe_n[i] = 1'b1;
      // invalid codes fall back to input, the safe choice for a pad
      unique case (fn)
        mpfc_pkg::FN_OD:
        begin
          next_s.pins.o[i]    = 1'b0;
          next_s.pins.oe_n[i] = next_s.out_val[i];
        end
        mpfc_pkg::FN_PP:
        begin
          next_s.pins.o[i]    = next_s.out_val[i];
          next_s.pins.oe_n[i] = 1'b0;
        end
        mpfc_pkg::FN_MODEM_OD:
        begin
          next_s.pins.o[i]    = 1'b0;
          next_s.pins.oe_n[i] = modem_terminal_ready;
        end
        mpfc_pkg::FN_MODEM_PP:
        begin
          next_s.pins.o[i]    = modem_terminal_ready;
          next_s.pins.oe_n[i] = 1'b0;
        end
        default:
        begin
          next_s.pins.o[i]    = 1'b1;
          next_s.pins.oe_n[i] = 1'b1;
        end
      endcase
      // pulls follow the function, not oe_n: a released open drain
      // output is still an output and keeps its pulls off
      drv = fn inside {mpfc_pkg::FN_OD, mpfc_pkg::FN_PP,
                       mpfc_pkg::FN_MODEM_OD, mpfc_pkg::FN_MODEM_PP};
      next_s.pins.pull_up[i] = next_s.cfg[i][mpfc_pkg::POS_PULL_UP]
                               && !drv;
      next_s.pins.pull_dn[i] = next_s.cfg[i][mpfc_pkg::POS_PULL_DN]
                               && !next_s.cfg[i][mpfc_pkg::POS_PULL_UP]
                               && !drv;
    end
  end

  // =====================================================================
  // state register
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      s         <= '0;
      s.cfg     <= {mpfc_pkg::NUM_PINS{mpfc_pkg::CFG_RESET}};
      s.out_val <= mpfc_pkg::OUT_RESET;
      s.pins.o    <= 4'hF;
      s.pins.oe_n <= 4'hF;
    end
    else
      s <= next_s;
  end

  // outputs straight from the state flops
  assign pready       = s.pready;
  assign prdata       = s.prdata;
  assign pslverr      = s.pslverr;
  assign pin_o        = s.pins.o;
  assign pin_oe_n     = s.pins.oe_n;
  assign pull_up_en   = s.pins.pull_up;
  assign pull_down_en = s.pins.pull_dn;

  // =====================================================================
  // checks
  sequence wr_cfg(logic [7:0] ix, logic [7:0] d);
    psel && penable && pwrite && paddr[1:0] == 2'b00
      && paddr[ADDR_W-1:2] == ix && pwdata[7:0] == d;
  endsequence

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  chk_pullup_output_off: assert property (
    wr_cfg(mpfc_pkg::IDX_CD_CFG, 8'h81) |=> !pull_up_en[0])
    else $error("pull-up on while carrier pin drives");
  chk_pulldown_pullup_wins: assert property (
    wr_cfg(mpfc_pkg::IDX_RI_CFG, 8'hC0) |=> pull_up_en[1] && !pull_down_en[1])
    else $error("pull-down on while pull-up set");
  chk_pulldown_input_on: assert property (
    wr_cfg(mpfc_pkg::IDX_DSR_CFG, 8'h40) |=> pull_down_en[3] && pin_oe_n[3])
    else $error("pull-down missing on input pin");
  chk_cd_push_pull: assert property (
    wr_cfg(mpfc_pkg::IDX_CD_CFG, 8'h02)
      |=> !pin_oe_n[0] && pin_o[0] == s.out_val[0] && !pull_up_en[0])
    else $error("carrier pin not push-pull");
  chk_cd_invalid_input: assert property (
    wr_cfg(mpfc_pkg::IDX_CD_CFG, 8'h03) |=> pin_oe_n[0] ##1 pin_oe_n[0])
    else $error("carrier invalid code drives pin");
  chk_ri_open_drain: assert property (
    wr_cfg(mpfc_pkg::IDX_RI_CFG, 8'h01)
      |=> !pin_o[1] && pin_oe_n[1] == s.out_val[1])
    else $error("ring pin not open drain");
  chk_dtr_modem_pp: assert property (
    wr_cfg(mpfc_pkg::IDX_DTR_CFG, 8'h04)
      |=> !pin_oe_n[2] && pin_o[2] == $past(modem_terminal_ready))
    else $error("terminal pin not modem push-pull");
  chk_dsr_invalid_input: assert property (
    wr_cfg(mpfc_pkg::IDX_DSR_CFG, 8'h03) |=> pin_oe_n[3] && !pull_up_en[3])
    else $error("set ready invalid code drives pin");
  chk_otp_load: assert property (
    $rose(s.loaded) |-> s.cfg[0] == ($past(otp_cfg[0]) & 8'hC3)
      && s.cfg[2] == ($past(otp_cfg[2]) & 8'hC7))
    else $error("OTP defaults not loaded");

endmodule

// ===== mpfc_pkg.sv
// package: register map, field layout and types of the modem pin config block
package mpfc_pkg;

  // =====================================================================
  // register indices (byte address is four times the index)
  localparam logic [7:0] IDX_CD_CFG   = 8'h2A;
  localparam logic [7:0] IDX_RI_CFG   = 8'h2B;
  localparam logic [7:0] IDX_DTR_CFG  = 8'h2C;
  localparam logic [7:0] IDX_DSR_CFG  = 8'h2D;
  localparam logic [7:0] IDX_OUT_VAL  = 8'h40;
  localparam logic [7:0] IDX_IN_LVL   = 8'h41;

  // =====================================================================
  // pin slots, shared by config array and pin vectors
  localparam int SLOT_CD  = 0;
  localparam int SLOT_RI  = 1;
  localparam int SLOT_DTR = 2;
  localparam int SLOT_DSR = 3;
  localparam int NUM_PINS = 4;

  // =====================================================================
  // field layout of a pin setting register
  localparam int POS_PULL_UP = 7;
  localparam int POS_PULL_DN = 6;
  localparam logic [7:0] MASK_FUNC2 = 8'hC3;   // two-bit function field
  localparam logic [7:0] MASK_FUNC3 = 8'hC7;   // three-bit function field
  localparam logic [7:0] CFG_RESET  = 8'h00;
  localparam logic [3:0] OUT_RESET  = 4'h0;

  // function codes
  localparam logic [2:0] FN_IN       = 3'h0;
  localparam logic [2:0] FN_OD       = 3'h1;
  localparam logic [2:0] FN_PP       = 3'h2;
  localparam logic [2:0] FN_MODEM_OD = 3'h3;
  localparam logic [2:0] FN_MODEM_PP = 3'h4;

  // =====================================================================
  // types
  typedef logic [NUM_PINS-1:0][7:0] mpfc_cfg_arr_t;

  typedef struct packed {
    logic [NUM_PINS-1:0] o;       // level to drive
    logic [NUM_PINS-1:0] oe_n;    // low while driving
    logic [NUM_PINS-1:0] pull_up;
    logic [NUM_PINS-1:0] pull_dn;
  } mpfc_pins_t;

  typedef struct packed {
    logic                loaded;
    mpfc_cfg_arr_t       cfg;
    logic [NUM_PINS-1:0] out_val;
    logic [NUM_PINS-1:0] sync1;
    logic [NUM_PINS-1:0] sync2;
    logic                pready;
    logic [31:0]         prdata;
    logic                pslverr;
    mpfc_pins_t          pins;
  } mpfc_state_t;

endpackage

// ===== tb_top.sv
// testbench: APB stimulus and pin checks for the modem pin config block
`timescale 1ns/1ps

module tb_top;
  // =====================================================================
  // signals
  logic                    pclk;
  logic                    presetn;
  logic                    psel;
  logic                    penable;
  logic                    pwrite;
  logic [11:0]             paddr;
  logic [31:0]             pwdata;
  logic                    pready;
  logic [31:0]             prdata;
  logic                    pslverr;
  mpfc_pkg::mpfc_cfg_arr_t otp_cfg;
  logic                    modem_terminal_ready;
  logic [3:0]              pin_in;
  logic [3:0]              pin_o;
  logic [3:0]              pin_oe_n;
  logic [3:0]              pull_up_en;
  logic [3:0]              pull_down_en;
  logic [31:0]             lfsr;
  logic [31:0]             rd;
  logic                    err;
  mpfc_pkg::mpfc_cfg_arr_t cfg_m;
  logic [3:0]              ov_m;
  logic [7:0]              c;
  int                      s;
  int                      errors;
  int                      n_compared;

  // corner cases {slot, setting}, invalid codes among them; used from top
  localparam logic [9:0][9:0] CORNER = {10'h003, 10'h081, 10'h002,
    10'h1C0, 10'h101, 10'h103, 10'h204, 10'h287, 10'h303, 10'h340};

  mpfc_top i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pready(pready), .prdata(prdata), .pslverr(pslverr), .otp_cfg(otp_cfg),
    .modem_terminal_ready(modem_terminal_ready), .pin_in(pin_in),
    .pin_o(pin_o), .pin_oe_n(pin_oe_n), .pull_up_en(pull_up_en),
    .pull_down_en(pull_down_en));

  // =====================================================================
  // clock, watchdog and reference functions
  initial
  begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  // generous bound: the whole sequence needs about 810 cycles
  initial
  begin
    repeat (20000) @(posedge pclk);
    errors++;
    conclude();
  end

  function automatic logic [31:0] next_rand(input logic [31:0] v);
    next_rand = {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction

  // reserved bits are not stored, so they read back as zero
  function automatic logic [7:0] masked(input int k, input logic [7:0] v);
    masked = v & ((k == 2) ? mpfc_pkg::MASK_FUNC3 : mpfc_pkg::MASK_FUNC2);
  endfunction

  // expected {o, oe_n, pull_up, pull_down}; unknown codes act as input
  function automatic logic [3:0] exp_pin(input int k, input logic [7:0] v,
                                         input logic ov, input logic md);
    logic [2:0] f;
    logic       drv;
    logic       o;
    logic       oe;
    f   = (k == 2) ? v[2:0] : {1'b0, v[1:0]};
    drv = f == 3'h1 || f == 3'h2 || (k == 2 && (f == 3'h3 || f == 3'h4));
    o   = !drv ? 1'b1 : (f == 3'h1 || f == 3'h3) ? 1'b0
        : (f == 3'h2) ? ov : md;
    oe  = !drv ? 1'b1 : (f == 3'h1) ? ov : (f == 3'h3) ? md : 1'b0;
    exp_pin = {o, oe, v[7] & !drv, v[6] & !v[7] & !drv};
  endfunction

  // =====================================================================
  // tasks
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      errors++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // entered just after a rising edge; leaves one idle edge behind
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // no count of its own: only the watchdog ends a stalled access
    do
      @(posedge pclk);
    while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic check_pins();
    logic [3:0] e;
    for (int k = 0; k < 4; k++)
    begin
      e = exp_pin(k, cfg_m[k], ov_m[k], modem_terminal_ready);
      check(32'({pin_o[k], pin_oe_n[k]}), 32'(e[3:2]));
      check(32'({pull_up_en[k], pull_down_en[k]}), 32'(e[1:0]));
    end
  endtask

  // reset with fresh defaults, then defaults must show on pins and reads
  task automatic do_reset();
    lfsr = next_rand(lfsr);
    presetn <= 1'b0;
    otp_cfg <= lfsr;
    repeat (10) @(posedge pclk);
    check({pin_o, pin_oe_n, pull_up_en, pull_down_en}, 32'hFF00);
    presetn <= 1'b1;
    for (int k = 0; k < 4; k++)
      cfg_m[k] = masked(k, lfsr[8*k +: 8]);
    ov_m = 4'h0;
    repeat (3) @(posedge pclk);
    check_pins();
    for (int k = 0; k < 4; k++)
    begin
      apb(1'b0, 12'h0A8 + 12'(4 * k), 32'h0);
      check(rd, {24'h0, cfg_m[k]});
    end
  endtask

  task automatic conclude();
    if (errors == 0 && n_compared > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // =====================================================================
  // main sequence: every legal code on every pin, refusals, second reset
  initial
  begin
    errors = 0;
    n_compared = 0;
    lfsr = 32'h00000061;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    otp_cfg = 32'h0;
    modem_terminal_ready = 1'b0;
    pin_in = 4'h0;
    @(posedge pclk);
    do_reset();
    for (int i = 0; i < 60; i++)
    begin
      lfsr = next_rand(lfsr);
      s = i % 4;
      c = (s == 2) ? 8'((i / 4) % 5) : 8'((i / 4) % 3);
      // set ready stays the modem input while terminal ready is modem
      if (s == 3 && cfg_m[2][2:0] > 3'h2)
        c = 8'h00;
      c = c | (lfsr[7:0] & 8'hC0);
      modem_terminal_ready <= lfsr[8];
      pin_in <= lfsr[12:9];
      apb(1'b1, 12'h100, {28'h0, lfsr[16:13]});
      ov_m = lfsr[16:13];
      apb(1'b1, 12'h0A8 + 12'(4 * s), {24'h0, c});
      cfg_m[s] = c;
      check_pins();
      apb(1'b0, 12'h0A8 + 12'(4 * s), 32'h0);
      check({err, rd[30:0]}, {24'h0, c});
      apb(1'b0, 12'h104, 32'h0);
      check(rd, {28'h0, pin_in});
    end
    // hand-picked settings; invalid codes must leave the pin an input
    for (int j = 9; j >= 0; j--)
    begin
      s = int'(CORNER[j][9:8]);
      c = CORNER[j][7:0];
      apb(1'b1, 12'h0A8 + 12'(4 * s), {24'h0, c});
      cfg_m[s] = masked(s, c);
      check_pins();
    end
    // misaligned, unmapped and read-only places are refused
    apb(1'b0, 12'h0A9, 32'h0);
    check({err, rd[30:0]}, 32'h80000000);
    apb(1'b1, 12'h0C0, 32'h000000FF);
    check({31'h0, err}, 32'h1);
    apb(1'b1, 12'h104, 32'h0000000F);
    check({31'h0, err}, 32'h1);
    check_pins();
    do_reset();
    conclude();
  end
endmodule
